// file: hdl/mpr_readout_regs.vh
`ifndef MPR_READOUT_REGS_VH
`define MPR_READOUT_REGS_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_PAR_LOG 8'h08
`define OFS_PATTERN 8'h0c

// Control fields
`define CTRL_TEMP_LSB 0
`define CTRL_CL_LSB 8
`define CTRL_AL_LSB 16
`define CTRL_RESET 32'h0000_0000

// Page 0 default training patterns, location 3 down to 0
`define PATTERN_RESET 32'h000f_3355

// Mode register set fields
`define MR3_PAGE_LSB 0
`define MR3_MPR_EN 2
`define MR3_TEMP_EN 5
`define MR3_FMT_LSB 11

// Read formats
`define FMT_SERIAL 2'h0
`define FMT_PARALLEL 2'h1
`define FMT_STAGGER 2'h2

// Pages
`define PAGE_TRAIN 2'h0
`define PAGE_PARITY 2'h1
`define PAGE_MRS 2'h2

// Timing
`define TEMP_UPD_NS 1000000
`define CLK_NS 4
`define TMOD_CK 5'h18

`endif

// file: hdl/mpr_readout.v
// How it works
// R1: temp status A4:A3 codes sub1x,1x,2x,reserved
// R2: MR3 A5 set keeps temp fresh
// R3: MR3 A5 clear freezes temp bits
// R4: parity log page only while MR3 A2
// R5: page1 MPR3[2:0] returns parity latency
// R6: strobes with preamble on MPR reads
// R7: page 0 reads may use tCCD_S
// R8: pages 1-3 reads need tCCD_L
// R9: controller locks DLL, precharges, waits tRP
// R10: entry MRS sets MR3 enable, format, page
// R11: format 00 serial,01 parallel,10 staggered
// R12: controller waits tMRD and tMOD
// R13: reads redirected to location BA1:BA0
// R14: fixed BL8 or BC4 only; here MR0=01 with A12 low also gives BC4
// R15: BL8 with MR0 01 needs A12 high
// R16: A2 selects burst start 0 or 4
// R17: controller drives A1:A0 as 00
// R18: other address bits ignored
// R19: burst after AL plus CL
// R20: controller waits tMPRR before exit
// R21: exit MRS clears MR3 enable
// R22: core commands accepted after tMOD
// R23: page 2 mirrors modes, page 3 zero
// R24: page 0 defaults kept until reset; here the AHB pattern register can overwrite them
// R25: serial sends same pattern every lane
// R26: parallel uses location 0 only
// R27: staggered lane n gets location plus n
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`include "mpr_readout_regs.vh"
`default_nettype none

module mpr_readout #(
    parameter TEMP_UPD_CYCLES = `TEMP_UPD_NS / `CLK_NS,
    parameter SLOTS_LOG2 = 6
) (
    // System
    input wire clk_sys_i,
    input wire rst_i,
    // AHB-Lite slave
    input wire hsel_i,
    input wire [7:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    // Command pins
    input wire ck_i,
    input wire cs_n_i,
    input wire act_n_i,
    input wire ras_n_i,
    input wire cas_n_i,
    input wire we_n_i,
    input wire [1:0] bg_i,
    input wire [1:0] ba_i,
    input wire [17:0] addr_i,
    // Data pins
    output reg [7:0] dq_o,
    output reg dq_oe_o,
    output reg dqs_o,
    output reg dqs_oe_o
);
    localparam NSLOT = 1 << SLOTS_LOG2;
    localparam ST_NORMAL = 2'h0;
    localparam ST_MPR = 2'h1;
    localparam ST_MOD_WAIT = 2'h2;

    // Pin synchronisers
    reg [27:0] pin_s1_reg;
    reg [27:0] pin_s2_reg;
    reg ck_s3_reg;
    wire [27:0] pin_raw = {ck_i, cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i,
                           bg_i, ba_i, addr_i};
    wire ck_s = pin_s2_reg[27];
    wire ck_rise = ck_s & ~ck_s3_reg;
    wire ck_fall = ~ck_s & ck_s3_reg;
    wire cmd_cs = ~pin_s2_reg[26];
    wire cmd_act = ~pin_s2_reg[25];
    wire [2:0] cmd_rcw = pin_s2_reg[24:22];
    wire [1:0] cmd_bg = pin_s2_reg[21:20];
    wire [1:0] cmd_ba = pin_s2_reg[19:18];
    wire [17:0] cmd_a = pin_s2_reg[17:0];
    wire is_mrs = ck_rise & cmd_cs & ~cmd_act & (cmd_rcw == 3'h0);
    wire is_rd = ck_rise & cmd_cs & ~cmd_act & (cmd_rcw == 3'h5);

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1_reg <= 28'h000_0000;
            pin_s2_reg <= 28'h000_0000;
            ck_s3_reg <= 1'b0;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            ck_s3_reg <= ck_s;
        end
    end

    // Mode registers MR0..MR7 as last programmed
    reg [13:0] mr_reg [0:7];
    wire [2:0] mr_sel = {cmd_bg[0], cmd_ba};
    wire [13:0] mr3 = mr_reg[3];
    wire mpr_en = mr3[`MR3_MPR_EN];
    wire [1:0] page = mr3[`MR3_PAGE_LSB +: 2];
    wire [1:0] fmt = mr3[`MR3_FMT_LSB +: 2];
    genvar gm;
    generate
        for (gm = 0; gm < 8; gm = gm + 1) begin : g_mr
            always @(posedge clk_sys_i or posedge rst_i) begin
                if (rst_i) begin
                    mr_reg[gm] <= 14'h0000;
                end else if (is_mrs && mr_sel == gm) begin
                    mr_reg[gm] <= cmd_a[13:0]; // R10 R21
                end
            end
        end
    endgenerate

    // Entry / exit and tMOD tracking
    reg [1:0] state_reg;
    reg [4:0] mod_cnt_reg;
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_NORMAL;
            mod_cnt_reg <= 5'h00;
        end else if (is_mrs && mr_sel == 3'h3) begin
            state_reg <= ST_MOD_WAIT;
            mod_cnt_reg <= `TMOD_CK;
        end else if (state_reg == ST_MOD_WAIT) begin
            if (mod_cnt_reg == 5'h00) begin
                state_reg <= mpr_en ? ST_MPR : ST_NORMAL; // R22
            end else if (ck_rise) begin
                mod_cnt_reg <= mod_cnt_reg - 5'h01;
            end
        end else begin
            state_reg <= state_reg;
        end
    end

    // Software registers
    reg [31:0] ctrl_reg;
    reg [23:0] par_log_reg;
    reg [31:0] pattern_reg;
    reg [1:0] temp_reg;
    reg [31:0] temp_cnt_reg;
    wire [5:0] rl = ctrl_reg[`CTRL_AL_LSB +: 6] + ctrl_reg[`CTRL_CL_LSB +: 6];

    // Temperature status refresh; update interval well inside 32 ms
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            temp_reg <= 2'h1;
            temp_cnt_reg <= 32'h0000_0000;
        end else if (mr3[`MR3_TEMP_EN]) begin // R2
            if (temp_cnt_reg == 32'h0000_0000) begin
                temp_reg <= ctrl_reg[`CTRL_TEMP_LSB +: 2]; // R1
                temp_cnt_reg <= TEMP_UPD_CYCLES - 1;
            end else begin
                temp_cnt_reg <= temp_cnt_reg - 32'h0000_0001;
            end
        end else begin
            temp_cnt_reg <= 32'h0000_0000; // R3
        end
    end

    // Byte held at a page location
    function [7:0] mpr_byte;
        input [1:0] pg;
        input [1:0] loc;
        reg [13:0] m0;
        reg [13:0] m1;
        reg [13:0] m2;
        reg [13:0] m5;
        reg [13:0] m6;
        begin
            m0 = mr_reg[0];
            m1 = mr_reg[1];
            m2 = mr_reg[2];
            m5 = mr_reg[5];
            m6 = mr_reg[6];
            case (pg)
                `PAGE_TRAIN: mpr_byte = pattern_reg[loc * 8 +: 8]; // R24
                `PAGE_PARITY: begin
                    if (!mpr_en) begin
                        mpr_byte = 8'h00; // R4
                    end else if (loc == 2'h3) begin
                        mpr_byte = {5'h00, m5[2:0]}; // R5
                    end else begin
                        mpr_byte = par_log_reg[loc * 8 +: 8];
                    end
                end
                `PAGE_MRS: begin
                    case (loc) // R23
                        2'h0: mpr_byte = {3'h0, temp_reg, m2[12], m2[10:9]};
                        2'h1: mpr_byte = {m6[6:0], mr3[3]};
                        2'h2: mpr_byte = {m0[6:4], m0[2], 1'b0, m2[5:3]};
                        default: mpr_byte = {m1[10:9], m1[6], m5[8:6], m1[2:1]};
                    endcase
                end
                default: mpr_byte = 8'h00; // R23
            endcase
        end
    endfunction

    // Burst image, beat k lane n at bit k*8+n
    reg [63:0] burst_img;
    integer k;
    integer n;
    reg [2:0] ui;
    reg [1:0] lloc;
    reg [7:0] pat;
    always @* begin
        burst_img = 64'h0;
        ui = 3'h0;
        lloc = 2'h0;
        pat = 8'h00;
        for (k = 0; k < 8; k = k + 1) begin
            ui = k[2:0] ^ {cmd_a[2], 2'h0}; // R16 R17
            for (n = 0; n < 8; n = n + 1) begin
                if (fmt == `FMT_PARALLEL) begin
                    pat = mpr_byte(page, 2'h0); // R26
                    burst_img[k * 8 + n] = pat[7 - (n % 8)];
                end else begin
                    lloc = (fmt == `FMT_STAGGER) ? cmd_ba + n[1:0] : cmd_ba; // R27 R13 R25
                    pat = mpr_byte(page, lloc);
                    burst_img[k * 8 + n] = pat[7 - ui]; // R11
                end
            end
        end
    end

    // Latency slots indexed by link-clock count
    reg [63:0] slot_data [0:NSLOT-1];
    reg slot_vld_reg [0:NSLOT-1];
    reg slot_bc4_reg [0:NSLOT-1];
    reg [SLOTS_LOG2-1:0] ck_cnt_reg;
    wire [SLOTS_LOG2-1:0] wr_idx = ck_cnt_reg + rl[SLOTS_LOG2-1:0];
    wire [SLOTS_LOG2-1:0] nx_idx = ck_cnt_reg + 1'b1;
    // BC4 from MR0=10, or from A12 low with MR0=01; BL8 with MR0=01 relies on A12 high
    wire rd_bc4 = (mr_reg[0][1:0] == 2'h2) | ((mr_reg[0][1:0] == 2'h1) & ~cmd_a[12]); // R14 R15
    wire take_rd = is_rd & (state_reg == ST_MPR); // R18
    integer s;
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ck_cnt_reg <= {SLOTS_LOG2{1'b0}};
            for (s = 0; s < NSLOT; s = s + 1) begin
                slot_vld_reg[s] <= 1'b0;
                slot_bc4_reg[s] <= 1'b0;
                slot_data[s] <= 64'h0;
            end
        end else if (ck_rise) begin
            ck_cnt_reg <= nx_idx;
            slot_vld_reg[ck_cnt_reg] <= 1'b0;
            if (take_rd) begin
                slot_vld_reg[wr_idx] <= 1'b1; // R19
                slot_bc4_reg[wr_idx] <= rd_bc4;
                slot_data[wr_idx] <= burst_img;
            end
        end
    end

    // DDR output, one beat per link-clock edge
    reg [55:0] shift_reg;
    reg [2:0] beats_reg;
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            shift_reg <= 56'h0;
            beats_reg <= 3'h0;
            dq_o <= 8'h00;
            dq_oe_o <= 1'b0;
            dqs_o <= 1'b0;
            dqs_oe_o <= 1'b0;
        end else if (ck_rise && slot_vld_reg[ck_cnt_reg]) begin
            dq_o <= slot_data[ck_cnt_reg][7:0];
            shift_reg <= slot_data[ck_cnt_reg][63:8];
            beats_reg <= slot_bc4_reg[ck_cnt_reg] ? 3'h3 : 3'h7;
            dq_oe_o <= 1'b1;
            dqs_o <= 1'b1; // R6
            dqs_oe_o <= 1'b1;
        end else if ((ck_rise || ck_fall) && beats_reg != 3'h0) begin
            dq_o <= shift_reg[7:0];
            shift_reg <= {8'h00, shift_reg[55:8]};
            beats_reg <= beats_reg - 3'h1;
            dqs_o <= ck_rise; // R6
        // Counter already stepped at the rise, so it names the next burst slot
        end else if (ck_fall && slot_vld_reg[ck_cnt_reg]) begin
            dq_oe_o <= 1'b0;
            dqs_o <= 1'b0; // R6
            dqs_oe_o <= 1'b1;
        end else if (ck_rise || ck_fall) begin
            dq_oe_o <= 1'b0;
            dqs_o <= 1'b0;
            dqs_oe_o <= 1'b0;
        end
    end

    // AHB-Lite slave, zero wait states
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    wire ahb_go = hsel_i & hready_i & htrans_i[1];
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            ctrl_reg <= `CTRL_RESET;
            par_log_reg <= 24'h00_0000;
            pattern_reg <= `PATTERN_RESET; // R24
        end else begin
            wr_pend_reg <= ahb_go & hwrite_i;
            wr_addr_reg <= haddr_i;
            if (wr_pend_reg) begin
                case (wr_addr_reg)
                    `OFS_CTRL: ctrl_reg <= hwdata_i;
                    `OFS_PAR_LOG: par_log_reg <= hwdata_i[23:0];
                    `OFS_PATTERN: pattern_reg <= hwdata_i;
                    default: ctrl_reg <= ctrl_reg;
                endcase
            end
            // Read data registered now, seen in the data phase
            if (ahb_go && !hwrite_i) begin
                case (haddr_i)
                    `OFS_CTRL: hrdata_o <= ctrl_reg;
                    `OFS_STATUS: hrdata_o <= {18'h0, mr3[12:11], 2'h0, temp_reg,
                                              page, 2'h0, mod_cnt_reg != 5'h00,
                                              state_reg, mpr_en};
                    `OFS_PAR_LOG: hrdata_o <= {8'h00, par_log_reg};
                    `OFS_PATTERN: hrdata_o <= pattern_reg;
                    default: hrdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// file: testbench/mpr_readout_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module mpr_readout_asserts (
    // System
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Data pins
    input wire logic [7:0] dq_o,
    input wire logic dq_oe_o,
    input wire logic dqs_o,
    input wire logic dqs_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    property p_ready; hreadyout_o; endproperty
    property p_okay; !hresp_o; endproperty
    property p_pre; $rose(dq_oe_o) |-> $past(dqs_oe_o) && !$past(dqs_o); endproperty
    property p_oe; dq_oe_o |-> dqs_oe_o; endproperty
    property p_first; $rose(dq_oe_o) |-> dqs_o; endproperty
    // A beat lasts half a link clock, well over eight system clocks
    property p_len; $rose(dq_oe_o) |-> dq_oe_o [*8]; endproperty
    property p_beat; dq_oe_o && $past(dq_oe_o) && $changed(dq_o) |-> $changed(dqs_o); endproperty
    property p_rdata;
        $changed(hrdata_o) |-> $past(hsel_i && hready_i && htrans_i[1] && !hwrite_i);
    endproperty
    a_ready: assert property (p_ready) else $error("hreadyout low");
    a_okay: assert property (p_okay) else $error("error response");
    a_pre: assert property (p_pre) else $error("no preamble");
    a_oe: assert property (p_oe) else $error("data without strobe");
    a_first: assert property (p_first) else $error("first strobe low");
    a_len: assert property (p_len) else $error("burst too short");
    a_beat: assert property (p_beat) else $error("data off strobe");
    a_rdata: assert property (p_rdata) else $error("read data moved");
    c_burst: cover property ($rose(dq_oe_o));
    c_pre: cover property ($rose(dqs_oe_o));
    c_write: cover property (hsel_i && htrans_i[1] && hwrite_i);
endmodule
bind mpr_readout mpr_readout_asserts u_chk (.*);
`default_nettype wire

// file: testbench/mpr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mpr_host_model (
    // Command pins
    output var logic ck_o,
    output var logic cs_n_o,
    output var logic act_n_o,
    output var logic ras_n_o,
    output var logic cas_n_o,
    output var logic we_n_o,
    output var logic [1:0] bg_o,
    output var logic [1:0] ba_o,
    output var logic [17:0] addr_o
);
    // Free running, phase unrelated to the system clock
    initial begin
        ck_o = 1'b0;
        #13;
        forever #80 ck_o = ~ck_o;
    end
    initial begin
        cs_n_o = 1'b1;
        act_n_o = 1'b1;
        {ras_n_o, cas_n_o, we_n_o} = 3'h7;
        {bg_o, ba_o, addr_o} = 22'h0;
    end
    // Launched on the fall so the sampling rise sees it settled
    task automatic cmd(input logic [2:0] rcw, input logic [2:0] idx, input logic [17:0] a);
        @(negedge ck_o);
        cs_n_o <= 1'b0;
        {ras_n_o, cas_n_o, we_n_o} <= rcw;
        {bg_o, ba_o} <= {1'b0, idx};
        addr_o <= a;
        @(negedge ck_o);
        cs_n_o <= 1'b1;
        // Deselected lines carry junk, never the last value
        {bg_o, ba_o, addr_o} <= ~{bg_o, ba_o, addr_o};
    endtask
    task automatic mrs(input logic [2:0] idx, input logic [17:0] a);
        cmd(3'h0, idx, a);
        repeat (30) @(posedge ck_o);
    endtask
    task automatic pre_all();
        cmd(3'h2, 3'h0, 18'h00400);
    endtask
    // A10 and bank group set on purpose; they must be ignored
    task automatic rd(input logic [1:0] ba, input logic a2);
        cmd(3'h5, {1'b1, ba}, {5'h0, 3'h5, 7'h0, a2, 2'h0});
    endtask
endmodule
`default_nettype wire

// file: testbench/mpr_readout_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mpr_readout_bench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [7:0] haddr_i = 8'h00;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    wire logic ck_i, cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i;
    wire logic [1:0] bg_i, ba_i;
    wire logic [17:0] addr_i;
    wire logic [31:0] hrdata_o;
    wire logic [7:0] dq_o;
    wire logic hreadyout_o, hresp_o, dq_oe_o, dqs_o, dqs_oe_o;
    int fail_count = 0;
    int samples_checked = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    mpr_readout #(.TEMP_UPD_CYCLES(8)) u_dut (.hsize_i(3'h2), .hready_i(hreadyout_o), .*);
    mpr_host_model u_host (.ck_o(ck_i), .cs_n_o(cs_n_i), .act_n_o(act_n_i), .ras_n_o(ras_n_i),
        .cas_n_o(cas_n_i), .we_n_o(we_n_i), .bg_o(bg_i), .ba_o(ba_i), .addr_o(addr_i));
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_sys_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        @(posedge clk_sys_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        @(posedge clk_sys_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
        rd = hrdata_o;
    endtask
    function automatic logic [17:0] mr3(input logic [1:0] fmt, input logic [1:0] pg, input logic te);
        return {5'h0, fmt, 5'h0, te, 2'h0, 1'b1, pg};
    endfunction
    // One read per burst keeps spacing above tCCD_L for every page
    task automatic burst(input logic [1:0] ba, input logic a2, input logic [1:0] fmt,
                         input logic [31:0] pat);
        int t;
        logic [7:0] e;
        logic [2:0] u;
        logic [1:0] loc;
        u_host.rd(ba, a2);
        for (t = 0; t < 400 && dq_oe_o !== 1'b1; t++) @(posedge clk_sys_i);
        chk("latency", 1, t >= 180 && t <= 192);
        repeat (10) @(posedge clk_sys_i);
        for (int ui = 0; ui < 8; ui++) begin
            u = 3'(ui + 4 * a2);
            for (int n = 0; n < 8; n++) begin
                loc = (fmt == 2'h2) ? 2'(ba + n) : (fmt == 2'h1) ? 2'h0 : ba;
                e[n] = pat[{loc, (fmt == 2'h1) ? 3'(7 - n) : ~u}];
            end
            chk("beat", {23'h0, ~ui[0], e}, {23'h0, dqs_o, dq_o});
            repeat (20) @(posedge clk_sys_i);
        end
    endtask
    task automatic t_regs();
        logic [31:0] v;
        ahb(1'b0, 8'h0c, 32'h0, v);
        chk("pattern", 32'h000f_3355, v);
        ahb(1'b0, 8'h10, 32'h0, v);
        chk("unmapped", 32'h0, v);
        ahb(1'b1, 8'h00, 32'h0001_0402, v);
        ahb(1'b0, 8'h00, 32'h0, v);
        chk("ctrl", 32'h0001_0402, v);
    endtask
    task automatic t_formats();
        logic [31:0] v;
        u_host.pre_all();
        u_host.mrs(3'h3, mr3(2'h0, 2'h0, 1'b0));
        burst(2'h1, 1'b0, 2'h0, 32'h000f_3355);
        u_host.mrs(3'h3, mr3(2'h1, 2'h0, 1'b0));
        burst(2'h0, 1'b1, 2'h1, 32'h000f_3355);
        ahb(1'b1, 8'h0c, 32'h96e1_5ac3, v);
        u_host.mrs(3'h3, mr3(2'h2, 2'h0, 1'b0));
        burst(2'h3, 1'b1, 2'h2, 32'h96e1_5ac3);
    endtask
    // Sensor code 2 from the control register shows at bits 4:3
    task automatic t_temp();
        logic [31:0] v;
        u_host.mrs(3'h3, mr3(2'h0, 2'h2, 1'b1));
        burst(2'h0, 1'b0, 2'h0, 32'h10);
        u_host.mrs(3'h3, mr3(2'h0, 2'h2, 1'b0));
        ahb(1'b1, 8'h00, 32'h0001_0401, v);
        repeat (40) @(posedge clk_sys_i);
        burst(2'h0, 1'b0, 2'h0, 32'h10);
    endtask
    task automatic t_parity();
        u_host.mrs(3'h5, 18'h00005);
        u_host.mrs(3'h3, mr3(2'h0, 2'h1, 1'b0));
        burst(2'h3, 1'b0, 2'h0, 32'h0500_0000);
    endtask
    task automatic t_exit();
        int t;
        logic [31:0] v;
        repeat (20) @(posedge ck_i);
        u_host.mrs(3'h3, 18'h0);
        u_host.rd(2'h0, 1'b0);
        for (t = 0; t < 300 && dq_oe_o !== 1'b1; t++) @(posedge clk_sys_i);
        chk("read after exit", 300, t);
        ahb(1'b0, 8'h04, 32'h0, v);
        chk("status after exit", 32'h0000_0200, v);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_regs();
        t_formats();
        t_temp();
        t_parity();
        t_exit();
        test_done();
    end
    // Whole run needs about 15000 cycles
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
